// ===== rtl/touch_pkg.sv
// Functional notes
// - Measure five channels, results readable by host.
// - Filter field picks 1, 3, 5, 7 samples.
// - Field 0 passes single sample unchanged.
// - Field 1 averages three, scaled 4079/4095.
// - Field 2 averages five, scaled 4079/4095.
// - Field 3 median: middle three averaged, scaled.
// - Settling delay between same-channel samples, 0.5us min.
// - Reset enters host mode, acquisition stopped.
// - Host mode converts only on host commands.
// - Host mode runs each command then idles.
// - Convert checks pen first; pen flag frozen.
// - Convert: bias channel, wait bias delay, convert.
// - Sequence convert walks masked channels, unbiases each.
// - Pre-selected channel converts without pen check.
// - End flags status, line low until read.
// - Pen mode: detection only, paced by ticks while pen down, continuous while up.
// - Tick skipped while interrupt line is low.
// - Pen touch/release toggles flag, may interrupt.
// - Pen check biases for bias delay over eight.
package touch_pkg;
	// --------------------
	// Register map
	// --------------------
	localparam logic [3:0] A_CTRL    = 4'h0;
	localparam logic [3:0] A_BIAS    = 4'h1;
	localparam logic [3:0] A_SETTLE  = 4'h2;
	localparam logic [3:0] A_SCAN    = 4'h3;
	localparam logic [3:0] A_CHMASK  = 4'h4;
	localparam logic [3:0] A_IRQMASK = 4'h5;
	localparam logic [3:0] A_CMD     = 4'h6;
	localparam logic [3:0] A_STATUS  = 4'h7;
	localparam logic [3:0] A_INTERRUPT_SOURCE  = 4'h8;
	localparam logic [3:0] A_DATA0   = 4'h9;
	// --------------------
	// Fields, resets, timing
	// --------------------
	localparam int        NCHAN          = 5;
	localparam logic [2:0] CH_SEQ        = 3'h7;
	localparam int        CLK_NS         = 10;
	localparam int        SETTLE_MIN_NS  = 500;
	localparam int        SETTLE_MIN_CYC =
		(SETTLE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [23:0] BIAS_RST     = 24'h000032;
	localparam logic [23:0] SETTLE_RST   = 24'h000032;
	localparam logic [4:0]  CHMASK_RST   = 5'h03;
	localparam int        PEN_SHIFT      = 3;
	localparam int        SCALE_NUM      = 4079;
	localparam int        SCALE_DEN      = 4095;
	localparam int        CMD_CH_LSB     = 2;
	typedef enum logic [1:0] {
		CMD_MANUAL  = 2'h0,
		CMD_PEN_DETECT_MODE  = 2'h1,
		CMD_SELECT  = 2'h2,
		CMD_CONVERT = 2'h3
	} cmd_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [23:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
	typedef struct packed {
		logic       bias_en;
		logic [2:0] bias_chan;
		logic       pen_bias;
		logic       adc_start;
	} afe_ctl_t;
endpackage

// ===== rtl/sample_filter.sv
`timescale 1ns/1ps
module sample_filter #(
	parameter int DEPTH = 7
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        clear,
	input  wire logic        sample_valid,
	input  wire logic [11:0] sample,
	input  wire logic [1:0]  filt,
	output logic      [11:0] result
);
	import touch_pkg::*;
	logic [11:0] s [DEPTH];
	logic [2:0]  n;
	logic [2:0]  p;
	logic [15:0] sum;
	logic [31:0] scaled;
	// Samples are kept sorted on arrival, so no sort network is needed.
	always_comb begin
		p = 3'h0;
		for (int i = 0; i < DEPTH; i++) begin
			if (3'(i) < n && s[i] >= sample) begin
				p = p + 3'h1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			n <= 3'h0;
			for (int i = 0; i < DEPTH; i++) begin
				s[i] <= 12'h000;
			end
		end else if (sample_valid) begin
			n <= n + 3'h1;
			for (int i = 0; i < DEPTH; i++) begin
				if (3'(i) == p) begin
					s[i] <= sample;
				end else if (3'(i) > p && i > 0) begin
					s[i] <= s[i-1];
				end
			end
		end
	end
	always_comb begin
		sum = 16'h0000;
		scaled = 32'h00000000;
		case (filt)
			2'h0: begin
				result = s[0];
			end
			2'h1: begin
				sum = 16'(s[0]) + 16'(s[1]) + 16'(s[2]);
				scaled = (32'(sum) * SCALE_NUM) / (3 * SCALE_DEN);
				result = scaled[11:0];
			end
			2'h2: begin
				sum = 16'(s[0]) + 16'(s[1]) + 16'(s[2]) + 16'(s[3])
					+ 16'(s[4]);
				scaled = (32'(sum) * SCALE_NUM) / (5 * SCALE_DEN);
				result = scaled[11:0];
			end
			default: begin
				sum = 16'(s[2]) + 16'(s[3]) + 16'(s[4]);
				scaled = (32'(sum) * SCALE_NUM) / (3 * SCALE_DEN);
				result = scaled[11:0];
			end
		endcase
	end
endmodule // sample_filter

// ===== rtl/touch_acquisition_sequencer.sv
`timescale 1ns/1ps
module touch_acquisition_sequencer #(
	parameter int NCH = touch_pkg::NCHAN
) (
	input  wire logic               sys_clk,
	input  wire logic               sys_rst,
	input  touch_pkg::reg_req_t     req,
	output logic             [23:0] rdata,
	input  wire logic               adc_done,
	input  wire logic        [11:0] adc_data,
	input  wire logic               pen_comp,
	output touch_pkg::afe_ctl_t     afe,
	output logic                    interrupt_line_n,
	output logic             [2:0]  x_range_code,
	output logic             [2:0]  y_range_code
);
	import touch_pkg::*;
	// --------------------
	// Sequencer states
	// --------------------
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_PEN    = 3'b001,
		S_BIAS   = 3'b011,
		S_CONV   = 3'b010,
		S_SETTLE = 3'b110,
		S_STORE  = 3'b111,
		S_NEXT   = 3'b101
	} state_t;
	state_t       state;
	logic [1:0]   filt;
	logic [23:0]  bias_delay;
	logic [23:0]  inter_sample_settling;
	logic [23:0]  scan_tick_interval;
	logic [4:0]   channel_mask;
	logic [1:0]   interrupt_mask;
	logic         pen_detect_mode;
	logic         pen_status;
	logic         conversion_status;
	logic         conv_irq;
	logic         pen_irq;
	logic [11:0]  data [NCH];
	logic [NCH-1:0] unread;
	logic         sel_valid;
	logic [2:0]   sel_chan;
	logic [2:0]   cur_ch;
	logic [4:0]   remaining;
	logic         job_conv;
	logic [23:0]  wait_cnt;
	logic [2:0]   samp_cnt;
	logic [23:0]  tick_cnt;
	logic         tick;
	logic [11:0]  filt_result;
	logic         cmd_wr;
	cmd_t         cmd_op;
	logic [2:0]   cmd_ch;
	logic [23:0]  pen_wait;
	logic [23:0]  settle_wait;
	logic [2:0]   last_samp;
	logic         data_rd;
	logic [2:0]   rd_ch;
	logic [NCH-1:0] next_unread;
	logic         pen_done;
	logic         conv_done;
	assign cmd_wr = req.wr && req.addr == A_CMD;
	assign cmd_op = cmd_t'(req.wdata[1:0]);
	assign cmd_ch = req.wdata[CMD_CH_LSB+2:CMD_CH_LSB];
	assign pen_wait = (bias_delay >> PEN_SHIFT) == 24'h000000 ?
		24'h000001 : bias_delay >> PEN_SHIFT;
	assign settle_wait = inter_sample_settling < 24'(SETTLE_MIN_CYC) ?
		24'(SETTLE_MIN_CYC) : inter_sample_settling;
	assign last_samp = {filt, 1'b1} - 3'h1;
	assign rd_ch = 3'(req.addr - A_DATA0);
	assign data_rd = req.rd && req.addr >= A_DATA0
		&& req.addr < A_DATA0 + 4'(NCH);
	assign pen_done = state == S_PEN && wait_cnt == 24'h000000;
	assign conv_done = state == S_NEXT && remaining == 5'h00;
	function automatic logic [2:0] low_ch(input logic [4:0] m);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (m[i]) begin
				c = 3'(i);
			end
		end
		return c;
	endfunction
	sample_filter #(
		.DEPTH(7)
	) u_filter (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.clear        (state == S_BIAS),
		.sample_valid (state == S_CONV && adc_done),
		.sample       (adc_data),
		.filt         (filt),
		.result       (filt_result)
	);
	// --------------------
	// Configuration registers
	// --------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			filt <= 2'h0;
			x_range_code <= 3'h0;
			y_range_code <= 3'h0;
			bias_delay <= BIAS_RST;
			inter_sample_settling <= SETTLE_RST;
			scan_tick_interval <= 24'h000000;
			channel_mask <= CHMASK_RST;
			interrupt_mask <= 2'h0;
		end else if (req.wr) begin
			case (req.addr)
				A_CTRL: begin
					filt <= req.wdata[1:0];
					x_range_code <= req.wdata[4:2];
					y_range_code <= req.wdata[7:5];
				end
				A_BIAS: bias_delay <= req.wdata;
				A_SETTLE: inter_sample_settling <= req.wdata;
				A_SCAN: scan_tick_interval <= req.wdata;
				A_CHMASK: channel_mask <= req.wdata[4:0];
				A_IRQMASK: interrupt_mask <= req.wdata[1:0];
				default: begin
				end
			endcase
		end
	end
	// --------------------
	// Mode and scan ticks
	// --------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pen_detect_mode <= 1'b0;
		end else if (cmd_wr && cmd_op == CMD_MANUAL) begin
			pen_detect_mode <= 1'b0;
		end else if (cmd_wr && cmd_op == CMD_PEN_DETECT_MODE && state == S_IDLE) begin
			pen_detect_mode <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pen_detect_mode
			|| scan_tick_interval == 24'h000000) begin
			tick_cnt <= 24'h000000;
			tick <= 1'b0;
		end else if (tick_cnt >= scan_tick_interval - 24'h000001) begin
			tick_cnt <= 24'h000000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 24'h000001;
			tick <= 1'b0;
		end
	end
	// --------------------
	// Acquisition sequencer
	// --------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (cmd_wr && cmd_op == CMD_MANUAL)) begin
			state <= S_IDLE;
			wait_cnt <= 24'h000000;
			samp_cnt <= 3'h0;
			cur_ch <= 3'h0;
			remaining <= 5'h00;
			job_conv <= 1'b0;
			sel_valid <= 1'b0;
			sel_chan <= 3'h0;
			afe <= '0;
		end else begin
			afe.adc_start <= 1'b0;
			case (state)
				S_IDLE: begin
					if (pen_detect_mode && (!pen_status
						|| (tick && interrupt_line_n))) begin
						state <= S_PEN;
						job_conv <= 1'b0;
						wait_cnt <= pen_wait;
						afe.pen_bias <= 1'b1;
					end else if (!pen_detect_mode && cmd_wr
						&& cmd_op == CMD_SELECT && cmd_ch != CH_SEQ) begin
						sel_valid <= 1'b1;
						sel_chan <= cmd_ch;
						afe.bias_en <= 1'b1;
						afe.bias_chan <= cmd_ch;
					end else if (!pen_detect_mode && cmd_wr
						&& cmd_op == CMD_CONVERT) begin
						job_conv <= 1'b1;
						remaining <= cmd_ch == CH_SEQ ? channel_mask
							: 5'h01 << cmd_ch;
						cur_ch <= cmd_ch == CH_SEQ ?
							low_ch(channel_mask) : cmd_ch;
						if (sel_valid && cmd_ch == sel_chan) begin
							state <= S_BIAS;
							wait_cnt <= bias_delay;
						end else begin
							state <= S_PEN;
							wait_cnt <= pen_wait;
							afe.bias_en <= 1'b0;
							afe.pen_bias <= 1'b1;
						end
						sel_valid <= 1'b0;
					end
				end
				// pen bias for delay over eight
				S_PEN: begin
					if (wait_cnt != 24'h000000) begin
						wait_cnt <= wait_cnt - 24'h000001;
					end else begin
						afe.pen_bias <= 1'b0;
						if (job_conv && pen_comp && remaining != 5'h00) begin
							state <= S_BIAS;
							wait_cnt <= bias_delay;
						end else begin
							state <= S_IDLE;
							job_conv <= 1'b0;
						end
					end
				end
				S_BIAS: begin
					afe.bias_en <= 1'b1;
					afe.bias_chan <= cur_ch;
					samp_cnt <= 3'h0;
					if (wait_cnt != 24'h000000) begin
						wait_cnt <= wait_cnt - 24'h000001;
					end else begin
						state <= S_CONV;
						afe.adc_start <= 1'b1;
					end
				end
				S_CONV: begin
					if (adc_done) begin
						if (samp_cnt == last_samp) begin
							state <= S_STORE;
						end else begin
							state <= S_SETTLE;
							samp_cnt <= samp_cnt + 3'h1;
							wait_cnt <= settle_wait;
						end
					end
				end
				S_SETTLE: begin
					if (wait_cnt != 24'h000000) begin
						wait_cnt <= wait_cnt - 24'h000001;
					end else begin
						state <= S_CONV;
						afe.adc_start <= 1'b1;
					end
				end
				S_STORE: begin
					state <= S_NEXT;
					remaining[cur_ch] <= 1'b0;
				end
				S_NEXT: begin
					afe.bias_en <= 1'b0;
					cur_ch <= low_ch(remaining);
					wait_cnt <= bias_delay;
					state <= remaining == 5'h00 ? S_IDLE : S_BIAS;
					job_conv <= remaining != 5'h00;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
	// --------------------
	// Results and status
	// --------------------
	always_comb begin
		next_unread = unread;
		if (data_rd) begin
			next_unread[rd_ch] = 1'b0;
		end
		if (state == S_STORE) begin
			next_unread[cur_ch] = 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			unread <= '0;
			for (int i = 0; i < NCH; i++) begin
				data[i] <= 12'h000;
			end
		end else begin
			unread <= next_unread;
			if (state == S_STORE) begin
				data[cur_ch] <= filt_result;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			conversion_status <= 1'b0;
		end else if (state == S_BIAS) begin
			conversion_status <= 1'b1;
		end else if (conv_done || state == S_IDLE) begin
			conversion_status <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pen_status <= 1'b0;
		end else if (pen_done && pen_detect_mode && !job_conv) begin
			pen_status <= pen_comp;
		end
	end
	// A new event wins over a read that clears in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			conv_irq <= 1'b0;
			pen_irq <= 1'b0;
		end else begin
			if (conv_done && interrupt_mask[0]) begin
				conv_irq <= 1'b1;
			end else if (data_rd && next_unread == '0) begin
				conv_irq <= 1'b0;
			end
			if (pen_done && pen_detect_mode && !job_conv
				&& pen_comp != pen_status && interrupt_mask[1]) begin
				pen_irq <= 1'b1;
			end else if (req.rd && req.addr == A_INTERRUPT_SOURCE) begin
				pen_irq <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			interrupt_line_n <= 1'b1;
		end else begin
			interrupt_line_n <= !(conv_irq || pen_irq);
		end
	end
	// --------------------
	// Register read port
	// --------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !req.rd) begin
			rdata <= 24'h000000;
		end else if (data_rd) begin
			rdata <= 24'(data[rd_ch]);
		end else begin
			case (req.addr)
				A_CTRL: rdata <= 24'({y_range_code, x_range_code, filt});
				A_BIAS: rdata <= bias_delay;
				A_SETTLE: rdata <= inter_sample_settling;
				A_SCAN: rdata <= scan_tick_interval;
				A_CHMASK: rdata <= 24'(channel_mask);
				A_IRQMASK: rdata <= 24'(interrupt_mask);
				A_STATUS: rdata <= 24'({state != S_IDLE, pen_detect_mode,
					pen_status, conversion_status});
				A_INTERRUPT_SOURCE: rdata <= 24'({pen_irq, conv_irq});
				default: rdata <= 24'h000000;
			endcase
		end
	end
	// --------------------
	// Assertions
	// --------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence conv_req_s;
		state == S_IDLE && !pen_detect_mode && cmd_wr
			&& cmd_op == CMD_CONVERT && !(sel_valid && cmd_ch == sel_chan);
	endsequence
	sequence pen_check_s;
		state == S_PEN && afe.pen_bias;
	endsequence
	a_reset_host_mode: assert property (
		$fell(sys_rst) |-> !pen_detect_mode && state == S_IDLE)
		else $error("not idle in host mode after reset");
	a_pen_check_first: assert property (
		conv_req_s |=> pen_check_s)
		else $error("convert did not start with pen check");
	a_pen_flag_frozen: assert property (
		!pen_detect_mode && !$past(pen_detect_mode) |-> $stable(pen_status))
		else $error("pen status changed in host mode");
	a_no_conv_pen_detect_mode: assert property (
		pen_detect_mode && $past(pen_detect_mode) |-> !afe.adc_start)
		else $error("conversion started in pen detect mode");
	a_pen_bias_time: assert property (
		$rose(afe.pen_bias) && pen_wait == 24'h000001
			|-> afe.pen_bias[*2] ##1 !afe.pen_bias)
		else $error("pen bias time wrong");
	a_start_biased: assert property (
		afe.adc_start |-> afe.bias_en && afe.bias_chan == cur_ch)
		else $error("conversion started on unbiased channel");
	a_settle_gap: assert property (
		state == S_CONV && adc_done && samp_cnt != last_samp
			|=> !afe.adc_start[*8])
		else $error("settling delay too short");
	a_line_follows: assert property (
		conv_irq || pen_irq |=> !interrupt_line_n)
		else $error("interrupt line not driven low");
	a_tick_skipped: assert property (
		state == S_IDLE && pen_detect_mode && pen_status && !interrupt_line_n
			|=> state == S_IDLE)
		else $error("pen check ran while line low");
	a_read_one_cycle: assert property (
		data_rd && state != S_STORE
			|=> rdata == 24'(data[$past(rd_ch)]) ##1 rdata == 24'h000000
			|| $past(req.rd))
		else $error("data read answer wrong");
endmodule // touch_acquisition_sequencer

// ===== test/afe_model.sv
`timescale 1ns/1ps
module afe_model (
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	input  touch_pkg::afe_ctl_t afe,
	input  wire logic          pen_down,
	input  wire logic          clr,
	input  wire logic [83:0]   vals,
	output logic               adc_done,
	output logic      [11:0]   adc_data,
	output logic               pen_comp,
	output int                 starts,
	output int                 pens,
	output int                 pen_len,
	output int                 bias_min,
	output int                 gap_min
);
	import touch_pkg::*;
	// --------------------
	// Converter and comparator
	// --------------------
	int   idx;
	int   dly;
	int   run_pen;
	int   run_bias;
	int   gap;
	logic pen_was;

	// Off bias the comparator shows the inverse, so a stale look is caught.
	assign pen_comp = afe.pen_bias ? pen_down : ~pen_down;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clr) begin
			idx      <= 0;
			dly      <= 0;
			run_pen  <= 0;
			run_bias <= 0;
			gap      <= 9999;
			starts   <= 0;
			pens     <= 0;
			pen_len  <= 0;
			bias_min <= 9999;
			gap_min  <= 9999;
			pen_was  <= 1'b0;
			adc_done <= 1'b0;
			adc_data <= 12'h5A5;
		end else begin
			adc_done <= 1'b0;
			// Data outside the done pulse keeps changing, never valid.
			adc_data <= ~adc_data;
			pen_was  <= afe.pen_bias;
			gap      <= gap + 1;
			run_bias <= afe.bias_en ? run_bias + 1 : 0;
			if (afe.pen_bias) begin
				run_pen <= run_pen + 1;
			end else if (run_pen != 0) begin
				pen_len <= run_pen;
				run_pen <= 0;
			end
			if (afe.pen_bias && !pen_was) begin
				pens <= pens + 1;
			end
			if (afe.adc_start) begin
				starts   <= starts + 1;
				dly      <= 3;
				bias_min <= (run_bias < bias_min) ? run_bias : bias_min;
				gap_min  <= (gap < gap_min) ? gap : gap_min;
			end else if (dly != 0) begin
				dly <= dly - 1;
				if (dly == 1) begin
					adc_done <= 1'b1;
					adc_data <= vals[idx*12 +: 12];
					idx      <= idx + 1;
					gap      <= 0;
				end
			end
		end
	end
endmodule // afe_model

// ===== test/touch_acquisition_sequencer_bench.sv
`timescale 1ns/1ps
module touch_acquisition_sequencer_bench;
	import touch_pkg::*;
	// --------------------
	// Signals and parts
	// --------------------
	logic        sys_clk  = 1'b0;
	logic        sys_rst  = 1'b1;
	reg_req_t    req      = '0;
	logic        pen_down = 1'b1;
	logic        clr      = 1'b0;
	logic [83:0] vals     = '0;
	logic [23:0] rdata;
	logic [23:0] d;
	logic [11:0] adc_data;
	logic        adc_done;
	logic        pen_comp;
	logic        interrupt_line_n;
	afe_ctl_t    afe;
	logic [2:0]  x_range_code;
	logic [2:0]  y_range_code;
	int          starts, pens, pen_len, bias_min, gap_min;
	int          bad_count = 0;
	int          checks    = 0;
	int          cyc       = 0;
	int          s[7];

	always #5 sys_clk = ~sys_clk;

	touch_acquisition_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req(req), .rdata(rdata), .adc_done(adc_done), .adc_data(adc_data),
		.pen_comp(pen_comp), .afe(afe), .interrupt_line_n(interrupt_line_n),
		.x_range_code(x_range_code), .y_range_code(y_range_code));

	afe_model far (.sys_clk(sys_clk), .sys_rst(sys_rst), .afe(afe),
		.pen_down(pen_down), .clr(clr), .vals(vals), .adc_done(adc_done),
		.adc_data(adc_data), .pen_comp(pen_comp), .starts(starts),
		.pens(pens), .pen_len(pen_len), .bias_min(bias_min),
		.gap_min(gap_min));

	// --------------------
	// Tasks and expectations
	// --------------------
	task automatic wr(input logic [3:0] a, input logic [23:0] v);
		@(posedge sys_clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk) req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk) req <= '{addr: a, wdata: 24'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk) req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic chk(input string n, input logic [23:0] e,
			input logic [23:0] g, input bit near);
		checks++;
		if (!(g === e || (near && (g === e + 24'h1 || g === e - 24'h1)))) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cyc_n(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_idle;
		int i;
		for (i = 0; i < 400; i++) begin
			rd(A_STATUS);
			if (d[3] === 1'b0) break;
		end
		chk("busy", 24'h0, {23'h0, d[3]}, 1'b0);
	endtask

	task automatic wait_low;
		int i;
		for (i = 0; i < 2000 && interrupt_line_n !== 1'b0; i++) cyc_n(1);
		chk("line low", 24'h0, {23'h0, interrupt_line_n}, 1'b0);
	endtask

	task automatic load(input bit pd);
		int i;
		@(posedge sys_clk) begin
			clr      <= 1'b1;
			pen_down <= pd;
			for (i = 0; i < 7; i++) vals[i*12 +: 12] <= 12'(s[i]);
		end
		@(posedge sys_clk) clr <= 1'b0;
	endtask

	function automatic logic [23:0] f_exp(input int f);
		int a[7];
		int i, j, t, n, sum;
		a   = s;
		n   = 2 * f + 1;
		sum = 0;
		if (f == 0) return 24'(a[0]);
		if (f == 3) begin
			for (i = 0; i < 7; i++)
				for (j = 0; j < 6 - i; j++)
					if (a[j] > a[j+1]) begin
						t = a[j]; a[j] = a[j+1]; a[j+1] = t;
					end
			sum = a[2] + a[3] + a[4];
			n   = 3;
		end else begin
			for (i = 0; i < n; i++) sum += a[i];
		end
		return 24'(sum * SCALE_NUM / (n * SCALE_DEN));
	endfunction

	task automatic conv(input int f, input int c, input bit hi);
		int i;
		logic [2:0] x, y;
		x = 3'($urandom_range(7));
		y = 3'($urandom_range(7));
		for (i = 0; i < 7; i++) s[i] = hi ? 4095 : $urandom_range(4095);
		wr(A_CTRL, {16'h0, y, x, 2'(f)});
		load(1'b1);
		chk("x code", {21'h0, x}, {21'h0, x_range_code}, 1'b0);
		chk("y code", {21'h0, y}, {21'h0, y_range_code}, 1'b0);
		wr(A_CMD, 24'(c * 4 + 3));
		wait_idle();
		chk("samples", 24'(2 * f + 1), 24'(starts), 1'b0);
		chk("bias wait", 24'h1, 24'(bias_min >= 16), 1'b0);
		chk("pen bias", 24'h1, 24'(pen_len >= 2), 1'b0);
		if (f > 0) chk("settle", 24'h1, 24'(gap_min >= 59), 1'b0);
		chk("status", 24'h0, {22'h0, d[1:0]}, 1'b0);
		chk("line", 24'h0, {23'h0, interrupt_line_n}, 1'b0);
		rd(4'(A_DATA0 + c));
		chk("result", f_exp(f), d, f != 0);
		cyc_n(2);
		chk("line up", 24'h1, {23'h0, interrupt_line_n}, 1'b0);
		$display("Test convert filter %0d channel %0d done", f, c);
	endtask

	task wrap_up;
		$display("Counts: %0d checks, %0d mismatches", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// A hang counts as a mismatch and closes the run.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			wrap_up();
		end
	end

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		void'($urandom(32'hC98C));
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cyc_n(1);
		chk("afe", 24'h0, {18'h0, afe}, 1'b0);
		chk("line", 24'h1, {23'h0, interrupt_line_n}, 1'b0);
		rd(A_STATUS);
		chk("status", 24'h0, d, 1'b0);
		rd(A_CHMASK);
		chk("mask", 24'h3, d, 1'b0);
		rd(A_BIAS);
		chk("bias", 24'h32, d, 1'b0);
		rd(4'hF);
		chk("unmapped", 24'h0, d, 1'b0);
		cyc_n(200);
		chk("idle", 24'h0, 24'(starts + pens), 1'b0);
		$display("Test reset done");
		wr(A_BIAS, 24'h10);
		wr(A_SETTLE, 24'h3C);
		wr(A_IRQMASK, 24'h1);
		for (int f = 0; f < 4; f++) conv(f, $urandom_range(4), 1'b0);
		conv(1, 4, 1'b1);
		conv(3, 0, 1'b0);
		load(1'b0);
		wr(A_CMD, 24'h3);
		wait_idle();
		chk("pen up", 24'h0, 24'(starts), 1'b0);
		chk("line", 24'h1, {23'h0, interrupt_line_n}, 1'b0);
		wr(A_CTRL, 24'h0);
		// Select is never paired with the sequence channel.
		wr(A_CMD, 24'h6);
		cyc_n(30);
		chk("select", 24'h9, {20'h0, afe.bias_en, afe.bias_chan}, 1'b0);
		wr(A_CMD, 24'h7);
		wait_idle();
		chk("no check", 24'h1, 24'(starts), 1'b0);
		rd(4'(A_DATA0 + 1));
		chk("sel data", 24'(s[0]), d, 1'b0);
		$display("Test pen up and select done");
		wr(A_CHMASK, 24'h5);
		load(1'b1);
		wr(A_CMD, 24'h1F);
		wait_idle();
		chk("seq count", 24'h2, 24'(starts), 1'b0);
		chk("bias off", 24'h0, {23'h0, afe.bias_en}, 1'b0);
		rd(A_DATA0);
		chk("seq ch0", 24'(s[0]), d, 1'b0);
		rd(4'(A_DATA0 + 2));
		chk("seq ch2", 24'(s[1]), d, 1'b0);
		$display("Test sequence done");
		wr(A_IRQMASK, 24'h2);
		// A bias of eight gives the shortest pen check of two cycles.
		wr(A_BIAS, 24'h8);
		// Interval goes in before the pen detect command.
		wr(A_SCAN, 24'h28);
		load(1'b0);
		wr(A_CMD, 24'h1);
		cyc_n(100);
		chk("pen polls", 24'h1, 24'(pens > 0), 1'b0);
		chk("pen len", 24'h2, 24'(pen_len), 1'b0);
		@(posedge sys_clk) pen_down <= 1'b1;
		wait_low();
		rd(A_STATUS);
		chk("pen flag", 24'h6, {21'h0, d[2:0]}, 1'b0);
		load(1'b1);
		cyc_n(150);
		chk("tick skip", 24'h0, 24'(pens + starts), 1'b0);
		rd(A_INTERRUPT_SOURCE);
		chk("irq src", 24'h1, {23'h0, d[1]}, 1'b0);
		cyc_n(150);
		chk("tick run", 24'h1, 24'(pens > 0), 1'b0);
		@(posedge sys_clk) pen_down <= 1'b0;
		wait_low();
		rd(A_STATUS);
		chk("release", 24'h0, {23'h0, d[1]}, 1'b0);
		rd(A_INTERRUPT_SOURCE);
		// Manual command first, then the zero interval.
		wr(A_CMD, 24'h0);
		wr(A_SCAN, 24'h0);
		rd(A_STATUS);
		chk("manual", 24'h0, {23'h0, d[2]}, 1'b0);
		$display("Test pen detect done");
		wrap_up();
	end
endmodule // touch_acquisition_sequencer_bench
